//--- hdl/amtt_pkg.sv
package amtt_pkg;
    // register offsets
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h41;
    localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
    localparam logic [7:0] MASK_ONE_ADDR = 8'h74;
    localparam logic [7:0] MASK_TWO_ADDR = 8'h75;
    localparam logic [7:0] CONFIG_THREE_ADDR = 8'h78;
    localparam logic [7:0] TIME_COUNT_ADDR = 8'h79;
    localparam logic [7:0] TIME_LIMIT_ADDR = 8'h7a;
    localparam logic [7:0] CONFIG_FOUR_ADDR = 8'h7d;
    // field positions
    localparam int SUMMARY_BIT = 7;
    localparam int FAN_FOUR_BIT = 5;
    localparam int OVERTEMP_BIT = 1;
    localparam int ALERT_EN_BIT = 0;
    localparam int THERMAL_THROTTLE_PIN_EN_BIT = 1;
    localparam int FULL_SPEED_ON_THROTTLE_BIT = 2;
    localparam logic [7:0] STATUS_ONE_USED = 8'h76;
    localparam logic [7:0] STATUS_TWO_USED = 8'hfe;
    // pin nine function codes
    localparam logic [1:0] PIN9_SPEED = 2'h1;
    localparam logic [1:0] PIN9_THERMAL = 2'h0;
    localparam logic [1:0] PIN9_ALERT = 2'h3;
    localparam logic [1:0] PIN9_GPIO = 2'h2;
    // reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] CONFIG_THREE_RESET = 8'h00;
    localparam logic [1:0] CONFIG_FOUR_RESET = PIN9_SPEED;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    // timing
    localparam real CLK_MHZ = 25.0;
    localparam real TIMER_LSB_MS = 22.76;
    localparam int unsigned TIMER_LSB_CYCLES =
        int'(TIMER_LSB_MS * CLK_MHZ * 1000.0);
endpackage : amtt_pkg

//--- hdl/amtt_timer_if.sv
`timescale 1ns/1ps
interface amtt_timer_if;
    logic active;
    logic rd_clr;
    logic [7:0] limit;
    logic [7:0] count;
    logic over;
    modport ctl (output active, output rd_clr, output limit,
                 input count, input over);
    modport tmr (input active, input rd_clr, input limit,
                 output count, output over);
endinterface : amtt_timer_if

//--- hdl/amtt_throttle_timer.sv
`timescale 1ns/1ps
module amtt_throttle_timer #(
    parameter int unsigned LSB_CYCLES = amtt_pkg::TIMER_LSB_CYCLES
) (
    input wire logic ref_clk, // block clock
    input wire logic rst, // synchronous reset
    input wire logic ce, // clock enable
    amtt_timer_if.tmr tif // timer control and result
);
    logic [19:0] pre_reg;
    logic [7:0] units_reg;
    logic seen_reg;

    ////////////////////////////////////////////////////////////////////////
    // accumulate assertion time in lsb units, saturating
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre_reg <= 20'h00000;
            units_reg <= 8'h00;
            seen_reg <= 1'b0;
        end else if (ce) begin
            if (tif.rd_clr) begin
                pre_reg <= 20'h00000;
                units_reg <= 8'h00;
                seen_reg <= tif.active;
            end else if (tif.active) begin
                seen_reg <= 1'b1;
                if (pre_reg == 20'(LSB_CYCLES - 1)) begin
                    pre_reg <= 20'h00000;
                    if (units_reg != amtt_pkg::COUNT_FULL) begin
                        units_reg <= units_reg + 8'h01;
                    end
                end else begin
                    pre_reg <= pre_reg + 20'h00001;
                end
            end
        end
    end

    // first assertion shows as 1 until two lsb units have passed
    assign tif.count = (units_reg == 8'h00 && seen_reg) ? 8'h01
                                                        : units_reg;
    assign tif.over = tif.count > tif.limit;
endmodule : amtt_throttle_timer

//--- hdl/amtt_top.sv
// Overview of operation
// - mask blocks alert, status still sets
// - mask one bit7 gates status-two summary
// - mask one bits suppress temp/supply alerts
// - mask two bits suppress diode/fan/overtemp
// - thermal mode: mask bit5 gates timer
// - alert off at reset; enable bit0 gates pin five only, pin nine alert needs only config four
// - config four selects pin nine function
// - thermal input idle until enable set
// - full_speed_on_throttle runs running fans full speed
// - timer counts only while input asserted
// - clear on read; saturate at full
// - bit0 first assertion; lsb 22.76ms
// - read during assertion restarts at one
// - timer compared to programmable limit
// - over limit sets status, alert unmasked
// - limit 0 first assertion; 1 later
// - status sticky except status two overtemp bit, which follows its cause; clears when ended
// - alert held until status read, except overtemp alert which drops when the cause ends
// - status one bit7 shows status two
`timescale 1ns/1ps
module amtt_top #(
    parameter int unsigned LSB_CYCLES = amtt_pkg::TIMER_LSB_CYCLES,
    parameter int FANS = 4
) (
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst, // synchronous reset
    input wire logic ce, // clock enable
    input wire logic [7:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, next cycle
    input wire logic [7:0] fault_one, // status one out-of-limit levels
    input wire logic [7:0] fault_two, // status two out-of-limit levels
    input wire logic [FANS-1:0] fan_running, // fan already running
    output logic [FANS-1:0] fan_full_speed_on_throttle, // force fan to full duty
    input wire logic pin9_in, // pin nine level
    output logic pin9_out, // pin nine drive level
    output logic pin9_oe, // pin nine drive enable
    output logic pin5_out, // pin five drive level
    output logic pin5_oe, // pin five drive enable
    output logic fan_four_speed_input // tach four level to fan logic
);
    logic [7:0] mask_one_reg;
    logic [7:0] mask_two_reg;
    logic [7:0] cfg_three_reg;
    logic [1:0] cfg_four_reg;
    logic [7:0] time_limit_reg;
    logic [7:0] status_one_reg;
    logic [7:0] status_two_reg;
    logic [7:0] reg_rdata_reg;
    logic p9_meta_reg;
    logic p9_sync_reg;
    logic alert_req_reg;
    logic pin5_oe_reg;
    logic pin9_oe_reg;
    logic speed_reg;
    logic [FANS-1:0] full_speed_on_throttle_reg;
    logic wr_en;
    logic rd_en;
    logic rd_st1;
    logic rd_st2;
    logic thermal_throttle_pin_sel;
    logic thermal_act;
    logic [7:0] st1_next;
    logic [7:0] st2_next;
    logic [7:0] cond_two;
    logic alert_next;

    amtt_timer_if tif ();

    amtt_throttle_timer #(
        .LSB_CYCLES(LSB_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign wr_en = ce & reg_wr;
    assign rd_en = ce & reg_rd;
    assign rd_st1 = rd_en && reg_addr == amtt_pkg::STATUS_ONE_ADDR;
    assign rd_st2 = rd_en && reg_addr == amtt_pkg::STATUS_TWO_ADDR;
    assign tif.rd_clr = rd_en
        && reg_addr == amtt_pkg::TIME_COUNT_ADDR;
    assign tif.limit = time_limit_reg;

    ////////////////////////////////////////////////////////////////////////
    // writable registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_one_reg <= amtt_pkg::MASK_RESET;
            mask_two_reg <= amtt_pkg::MASK_RESET;
            cfg_three_reg <= amtt_pkg::CONFIG_THREE_RESET;
            cfg_four_reg <= amtt_pkg::CONFIG_FOUR_RESET;
            time_limit_reg <= amtt_pkg::LIMIT_RESET;
        end else if (wr_en) begin
            unique case (reg_addr)
                amtt_pkg::MASK_ONE_ADDR: mask_one_reg <= reg_wdata;
                amtt_pkg::MASK_TWO_ADDR: mask_two_reg <= reg_wdata;
                amtt_pkg::CONFIG_THREE_ADDR: cfg_three_reg <= reg_wdata;
                amtt_pkg::CONFIG_FOUR_ADDR: cfg_four_reg <= reg_wdata[1:0];
                amtt_pkg::TIME_LIMIT_ADDR: time_limit_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin nine synchroniser and thermal input
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            p9_meta_reg <= 1'b1;
            p9_sync_reg <= 1'b1;
        end else if (ce) begin
            p9_meta_reg <= pin9_in;
            p9_sync_reg <= p9_meta_reg;
        end
    end

    assign thermal_throttle_pin_sel = cfg_four_reg == amtt_pkg::PIN9_THERMAL;
    assign thermal_act = thermal_throttle_pin_sel
        && cfg_three_reg[amtt_pkg::THERMAL_THROTTLE_PIN_EN_BIT]
        && !p9_sync_reg;
    assign tif.active = thermal_act;

    ////////////////////////////////////////////////////////////////////////
    // status registers: sticky except status two overtemp bit, cleared by read once cause ended
    always_comb begin
        cond_two = fault_two & amtt_pkg::STATUS_TWO_USED;
        cond_two[amtt_pkg::FAN_FOUR_BIT] = thermal_throttle_pin_sel ? tif.over
            : fault_two[amtt_pkg::FAN_FOUR_BIT];
        // a live cause wins over the read clear
        st1_next = (fault_one & amtt_pkg::STATUS_ONE_USED)
            | (rd_st1 ? 8'h00 : status_one_reg);
        st2_next = cond_two | (rd_st2 ? 8'h00 : status_two_reg);
        st2_next[amtt_pkg::OVERTEMP_BIT] =
            cond_two[amtt_pkg::OVERTEMP_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_one_reg <= 8'h00;
            status_two_reg <= 8'h00;
        end else if (ce) begin
            status_one_reg <= st1_next;
            status_two_reg <= st2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert: or of unmasked status bits plus gated summary
    always_comb begin
        alert_next = |(status_one_reg & ~mask_one_reg
                       & amtt_pkg::STATUS_ONE_USED)
            | |(status_two_reg & ~mask_two_reg
                & amtt_pkg::STATUS_TWO_USED)
            | (|status_two_reg
               & !mask_one_reg[amtt_pkg::SUMMARY_BIT]);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alert_req_reg <= 1'b0;
            pin5_oe_reg <= 1'b0;
            pin9_oe_reg <= 1'b0;
        end else if (ce) begin
            alert_req_reg <= alert_next;
            pin5_oe_reg <= alert_next
                && cfg_three_reg[amtt_pkg::ALERT_EN_BIT];
            pin9_oe_reg <= alert_next
                && cfg_four_reg == amtt_pkg::PIN9_ALERT;
        end
    end

    assign pin5_out = 1'b0;
    assign pin9_out = 1'b0;
    assign pin5_oe = pin5_oe_reg;
    assign pin9_oe = pin9_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // tach four pass-through and fan full_speed_on_throttle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            speed_reg <= 1'b1;
        end else if (ce) begin
            speed_reg <= cfg_four_reg == amtt_pkg::PIN9_SPEED
                ? p9_sync_reg : 1'b1;
        end
    end
    assign fan_four_speed_input = speed_reg;

    generate
        for (genvar i = 0; i < FANS; i++) begin : g_full_speed_on_throttle
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    full_speed_on_throttle_reg[i] <= 1'b0;
                end else if (ce) begin
                    full_speed_on_throttle_reg[i] <= thermal_act
                        && cfg_three_reg[amtt_pkg::FULL_SPEED_ON_THROTTLE_BIT]
                        && fan_running[i];
                end
            end
        end
    endgenerate
    assign fan_full_speed_on_throttle = full_speed_on_throttle_reg;

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else if (rd_en) begin
            unique case (reg_addr)
                amtt_pkg::STATUS_ONE_ADDR:
                    reg_rdata_reg <= {|status_two_reg,
                                      status_one_reg[6:0]};
                amtt_pkg::STATUS_TWO_ADDR: reg_rdata_reg <= status_two_reg;
                amtt_pkg::MASK_ONE_ADDR: reg_rdata_reg <= mask_one_reg;
                amtt_pkg::MASK_TWO_ADDR: reg_rdata_reg <= mask_two_reg;
                amtt_pkg::CONFIG_THREE_ADDR: reg_rdata_reg <= cfg_three_reg;
                amtt_pkg::TIME_COUNT_ADDR: reg_rdata_reg <= tif.count;
                amtt_pkg::TIME_LIMIT_ADDR: reg_rdata_reg <= time_limit_reg;
                amtt_pkg::CONFIG_FOUR_ADDR:
                    reg_rdata_reg <= {6'h00, cfg_four_reg};
                default: reg_rdata_reg <= 8'h00;
            endcase
        end
    end
    assign reg_rdata = reg_rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    mask_keeps_status_a: assert property (
        ce && fault_one[6] && mask_one_reg[6]
        |=> status_one_reg[6])
        else $error("masked source did not set its status bit");

    all_masked_quiet_a: assert property (
        (ce && mask_one_reg == 8'hff && mask_two_reg == 8'hff) [*2]
        |-> !alert_req_reg)
        else $error("alert raised with every mask set");

    summary_alert_a: assert property (
        ce && status_two_reg[7] && !mask_one_reg[amtt_pkg::SUMMARY_BIT]
        |=> alert_req_reg)
        else $error("summary did not raise alert");

    alert_pin_off_a: assert property (
        !cfg_three_reg[amtt_pkg::ALERT_EN_BIT] |=> !pin5_oe)
        else $error("pin five driven while alert disabled");

    thermal_throttle_pin_enable_a: assert property (
        !cfg_three_reg[amtt_pkg::THERMAL_THROTTLE_PIN_EN_BIT] |-> !tif.active)
        else $error("thermal input active while disabled");

    full_speed_on_throttle_running_a: assert property (
        ce && thermal_act && cfg_three_reg[amtt_pkg::FULL_SPEED_ON_THROTTLE_BIT]
        |=> fan_full_speed_on_throttle == $past(fan_running))
        else $error("full_speed_on_throttle does not follow running fans");

    timer_pause_a: assert property (
        ce && !tif.active && !tif.rd_clr |=> $stable(tif.count))
        else $error("timer moved while input idle");

    timer_hold_a: assert property (
        ce && tif.count == 8'hff && !tif.rd_clr |=> tif.count == 8'hff)
        else $error("saturated timer did not hold");

    read_restart_a: assert property (
        ce && tif.rd_clr && tif.active |=> tif.count == 8'h01)
        else $error("read during assertion did not restart at one");

    limit_status_a: assert property (
        ce && thermal_throttle_pin_sel && tif.over
        |=> status_two_reg[amtt_pkg::FAN_FOUR_BIT])
        else $error("over limit did not set status bit");

    sticky_status_a: assert property (
        ce && status_two_reg[7] && !rd_st2 |=> status_two_reg[7])
        else $error("sticky status bit lost without read");

    summary_read_a: assert property (
        rd_st1 && status_two_reg != 8'h00 |=> reg_rdata[7])
        else $error("status one summary bit missing");

    frozen_state_a: assert property (
        !ce |=> $stable(status_one_reg) && $stable(status_two_reg)
            && $stable(pin5_oe_reg) && $stable(tif.count))
        else $error("state moved while clock enable low");

    temp_alert_a: assert property (
        ce && status_one_reg[5] && !mask_one_reg[5] |=> alert_req_reg)
        else $error("unmasked local temperature gave no alert");

    fan_alert_a: assert property (
        ce && status_two_reg[2] && !mask_two_reg[2] |=> alert_req_reg)
        else $error("unmasked fan one status gave no alert");

    alert_held_a: assert property (
        ce && status_one_reg[2] && !mask_one_reg[2] |=> alert_req_reg)
        else $error("alert dropped while status still set");

    first_assert_a: assert property (
        ce && tif.active && tif.count == 8'h00 |=> tif.count == 8'h01)
        else $error("first assertion did not show one");

    limit_one_a: assert property (
        ce && thermal_throttle_pin_sel && time_limit_reg == 8'h01 && tif.count == 8'h02
        |=> status_two_reg[amtt_pkg::FAN_FOUR_BIT])
        else $error("limit one did not flag at two lsb units");

    pin9_alert_only_a: assert property (
        ce && cfg_four_reg != amtt_pkg::PIN9_ALERT |=> !pin9_oe)
        else $error("pin nine driven outside alert function");

    alert_seen_c: cover property (ce && pin5_oe_reg);
    timer_full_c: cover property (ce && tif.count == 8'hff);
    read_active_c: cover property (tif.rd_clr && tif.active);
    ce_frozen_c: cover property (!ce && fault_one != 8'h00);
    full_speed_on_throttle_on_c: cover property (ce && |fan_full_speed_on_throttle);
endmodule : amtt_top

//--- tb/amtt_hot_model.sv
`timescale 1ns/1ps
module amtt_hot_model (
    input wire logic pin9_oe, // device pulls pin nine low
    output logic pin9_level // resolved pin nine level
);
    logic lclk = 1'b0;
    logic hot_low = 1'b0;
    initial begin
        #13;
        forever #160 lclk = ~lclk;
    end
    // open-drain line with pull-up: low while either side pulls
    assign pin9_level = !(hot_low || pin9_oe);
    // hot signal held low for whole half periods of the 320 ns grid
    task automatic hold(input int halves);
        @(lclk);
        hot_low = 1'b1;
        repeat (halves) @(lclk);
        hot_low = 1'b0;
    endtask : hold
endmodule : amtt_hot_model

//--- tb/alert_mask_and_thermal_throttle_pin_timer_tb.sv
`timescale 1ns/1ps
module alert_mask_and_thermal_throttle_pin_timer_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] fault_one = 8'h00;
    logic [7:0] fault_two = 8'h00;
    logic [3:0] fan_running = 4'h0;
    logic ce = 1'b1;
    logic [3:0] fan_full_speed_on_throttle;
    logic pin9_level, pin9_out, pin9_oe, pin5_out, pin5_oe, f4_in;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] exp_q[$];

    amtt_top #(.LSB_CYCLES(8), .FANS(4)) amtt_top_inst (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fault_one(fault_one),
        .fault_two(fault_two), .fan_running(fan_running),
        .fan_full_speed_on_throttle(fan_full_speed_on_throttle), .pin9_in(pin9_level), .pin9_out(pin9_out),
        .pin9_oe(pin9_oe), .pin5_out(pin5_out), .pin5_oe(pin5_oe),
        .fan_four_speed_input(f4_in));
    amtt_hot_model amtt_hot_model_inst (.pin9_oe(pin9_oe),
        .pin9_level(pin9_level));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cb(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask : cb
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
    endtask : rd
    task automatic wait_low;
        int i;
        for (i = 0; i < 100 && pin9_level !== 1'b0; i++) cyc(1);
        if (i == 100) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : wait_low
    // read data lands on the taking edge; look half a cycle later
    always @(posedge ref_clk) begin
        if (reg_rd === 1'b1 && rst === 1'b0) begin
            @(negedge ref_clk);
            cmp(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] src[12];
        logic [7:0] adr[9];
        logic [7:0] rv[9];
        logic [7:0] b, sa, d;
        logic two, overtemp_flag;
        src = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h80, 8'h40, 8'h20,
            8'h10, 8'h08, 8'h04, 8'h02};
        adr = '{8'h74, 8'h75, 8'h7a, 8'h79, 8'h78, 8'h41, 8'h42, 8'h7d,
            8'h10};
        rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
            8'h00};
        void'($urandom(32'h5103f849));
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 9; i++) rd(adr[i], rv[i]);
        cb(pin5_oe, 1'b0);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            wr(adr[i], d);
            rd(adr[i], d);
        end
        wr(8'h42, 8'hff);
        rd(8'h42, 8'h00);
        wr(8'h7a, 8'h00);
        wr(8'h78, 8'h01);
        for (int i = 0; i < 12; i++) begin
            two = (i >= 5);
            overtemp_flag = (i == 11);
            b = src[i];
            sa = two ? 8'h42 : 8'h41;
            wr(8'h74, two ? 8'h80 : (8'h80 | b));
            wr(8'h75, two ? b : 8'h00);
            if (two) fault_two = b;
            else fault_one = b;
            cyc(3);
            cb(pin5_oe, 1'b0);
            rd(sa, b);
            if (two) rd(8'h41, 8'h80);
            wr(two ? 8'h75 : 8'h74, two ? 8'h00 : 8'h80);
            cyc(3);
            cb(pin5_oe, 1'b1);
            fault_one = 8'h00;
            fault_two = 8'h00;
            cyc(3);
            cb(pin5_oe, !overtemp_flag);
            rd(sa, overtemp_flag ? 8'h00 : b);
            cyc(3);
            cb(pin5_oe, 1'b0);
            rd(sa, 8'h00);
        end
        wr(8'h75, 8'hff);
        wr(8'h74, 8'h00);
        fault_two = 8'h08;
        cyc(1);
        fault_two = 8'h00;
        cyc(3);
        cb(pin5_oe, 1'b1);
        wr(8'h74, 8'h80);
        cyc(3);
        cb(pin5_oe, 1'b0);
        rd(8'h42, 8'h08);
        wr(8'h75, 8'h00);
        fork
            amtt_hot_model_inst.hold(2);
            begin
                wait_low();
                cyc(4);
                cb(f4_in, 1'b0);
            end
        join
        cyc(4);
        cb(f4_in, 1'b1);
        for (int m = 3; m >= 2; m--) begin
            wr(8'h7d, 8'(m));
            fault_one = 8'h02;
            cyc(3);
            cb(pin9_oe, m == 3);
            cb(f4_in, 1'b1);
            fault_one = 8'h00;
            rd(8'h41, 8'h02);
        end
        wr(8'h7d, 8'h00);
        amtt_hot_model_inst.hold(2);
        cyc(4);
        rd(8'h79, 8'h00);
        wr(8'h78, 8'h07);
        fan_running = 4'($urandom);
        wr(8'h75, 8'h20);
        fork
            amtt_hot_model_inst.hold(1);
            begin
                wait_low();
                cyc(3);
                cmp({4'h0, fan_full_speed_on_throttle}, {4'h0, fan_running});
            end
        join
        cyc(4);
        cmp({4'h0, fan_full_speed_on_throttle}, 8'h00);
        cb(pin5_oe, 1'b0);
        rd(8'h79, 8'h01);
        rd(8'h42, 8'h20);
        rd(8'h42, 8'h00);
        wr(8'h75, 8'h00);
        wr(8'h7a, 8'h01);
        amtt_hot_model_inst.hold(3);
        cyc(4);
        rd(8'h41, 8'h00);
        amtt_hot_model_inst.hold(4);
        cyc(4);
        cb(pin5_oe, 1'b1);
        rd(8'h42, 8'h20);
        wr(8'h75, 8'h20);
        cyc(3);
        cb(pin5_oe, 1'b0);
        rd(8'h79, 8'h03);
        rd(8'h42, 8'h20);
        rd(8'h42, 8'h00);
        wr(8'h75, 8'h00);
        amtt_hot_model_inst.hold(525);
        cyc(4);
        rd(8'h79, 8'hff);
        rd(8'h42, 8'h20);
        rd(8'h42, 8'h00);
        wr(8'h7a, 8'h00);
        fork
            amtt_hot_model_inst.hold(11);
            begin
                wait_low();
                cyc(20);
                rd(8'h79, 8'h02);
                rd(8'h79, 8'h01);
            end
        join
        cyc(4);
        rd(8'h79, 8'h02);
        rd(8'h42, 8'h20);
        rd(8'h42, 8'h00);
        cb(pin5_out, 1'b0);
        cb(pin9_out, 1'b0);
        ce = 1'b0;
        fault_one = 8'h04;
        cyc(4);
        cb(pin5_oe, 1'b0);
        ce = 1'b1;
        cyc(3);
        cb(pin5_oe, 1'b1);
        fault_one = 8'h00;
        rd(8'h41, 8'h04);
        wr(8'h74, 8'hff);
        wr(8'h75, 8'hff);
        fault_two = 8'h04;
        cyc(3);
        cb(pin5_oe, 1'b0);
        fault_two = 8'h00;
        rd(8'h42, 8'h04);
        cyc(2);
        report_and_stop();
    end
endmodule : alert_mask_and_thermal_throttle_pin_timer_tb
